// ### core/cxa_alu.sv
// Result and flag logic for compare, exclusive-OR and increment.
// Purely combinational; the caller decides what is stored.

`timescale 1ns/1ns
`default_nettype none

module cxa_alu (
  input wire cxa_pkg::cxa_op_t op_i,
  input wire logic [7:0] acc_i,
  input wire logic [7:0] src_i,
  input wire logic [7:0] flags_i,
  output logic [7:0] res_o,
  output logic [7:0] flags_o
);

  logic [8:0] diff;

  // --------------------------------------------------------------
  // Operation
  // --------------------------------------------------------------
  // Nine-bit difference keeps the borrow out of bit 7
  assign diff = {1'b0, acc_i} - {1'b0, src_i};

  always_comb
  begin
    res_o = acc_i;
    flags_o = flags_i;
    unique case (op_i)
      cxa_pkg::CXA_OP_XOR:
      begin
        res_o = acc_i ^ src_i;
        flags_o = 8'h00;
        flags_o[cxa_pkg::CXA_FLAG_S] = res_o[7];
        flags_o[cxa_pkg::CXA_FLAG_Z] = (res_o == 8'h00);
        flags_o[cxa_pkg::CXA_FLAG_PV] = ~^res_o;
      end
      cxa_pkg::CXA_OP_CP:
      begin
        res_o = diff[7:0];
        flags_o = 8'h00;
        flags_o[cxa_pkg::CXA_FLAG_S] = diff[7];
        flags_o[cxa_pkg::CXA_FLAG_Z] = (acc_i == src_i);
        flags_o[cxa_pkg::CXA_FLAG_H] = (acc_i[3:0] < src_i[3:0]);
        flags_o[cxa_pkg::CXA_FLAG_N] = 1'b1;
        flags_o[cxa_pkg::CXA_FLAG_PV] = (acc_i[7] ^ src_i[7]) & (acc_i[7] ^ diff[7]);
        flags_o[cxa_pkg::CXA_FLAG_C] = diff[8];
      end
      cxa_pkg::CXA_OP_INC:
      begin
        res_o = src_i + 8'h01;
        // Carry is kept from the previous flag byte
        flags_o[cxa_pkg::CXA_FLAG_S] = res_o[7];
        flags_o[cxa_pkg::CXA_FLAG_Z] = (res_o == 8'h00);
        flags_o[cxa_pkg::CXA_FLAG_H] = (src_i[3:0] == 4'hF);
        flags_o[cxa_pkg::CXA_FLAG_N] = 1'b0;
        flags_o[cxa_pkg::CXA_FLAG_PV] = (src_i == 8'h7F);
      end
      cxa_pkg::CXA_OP_NONE:
      begin
        res_o = acc_i;
      end
    endcase
  end

endmodule

`default_nettype wire

// ### core/cxa_core.sv
// Execution unit for compare, exclusive-OR and increment, with a Wishbone slave.
// Assumes a classic Wishbone master and a same-clock memory answering within a cycle.
//
// Our own choices: the register addresses and register access over Wishbone.

`timescale 1ns/1ns
`default_nettype none

module cxa_core (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Memory port
  output cxa_pkg::cxa_mem_req_t mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  // Status levels
  output logic busy_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  typedef enum logic {CXA_ST_IDLE, CXA_ST_EXEC} cxa_state_t;

  cxa_state_t state_q;
  cxa_pkg::cxa_plan_t plan_q;
  cxa_pkg::cxa_plan_t plan_d;
  logic [7:0] gpr_q [8];    // Slot 6 holds the flag byte; code 110 names no register
  logic [15:0] idx_x_q;
  logic [15:0] idx_y_q;
  logic [23:0] instr_q;
  logic [23:0] instr_d;
  logic [15:0] addr_q;
  logic [7:0] opnd_q;
  logic [7:0] wdata_q;
  logic [2:0] mi_q;
  logic [4:0] tcnt_q;
  logic [4:0] last_t_q;
  logic [2:0] last_m_q;
  logic illegal_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic bus_req;
  logic bus_wr;
  logic start;
  logic m_last;
  logic fin;
  logic rd_cyc;
  logic wr_cyc;
  logic mem_src;
  logic [7:0] src_byte;
  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic [15:0] disp_ext;
  logic [15:0] idx_base;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic cxa_pkg::cxa_plan_t decode(input logic [23:0] ins);
    cxa_pkg::cxa_plan_t p;
    logic [7:0] b0;
    logic [7:0] b1;
    b0 = ins[7:0];
    b1 = ins[15:8];
    p = '0;
    p.op = cxa_pkg::CXA_OP_NONE;
    p.src = cxa_pkg::CXA_SRC_REG;
    p.rsel = b0[2:0];
    p.imm = b1;
    p.disp = ins[23:16];
    p.mlen = cxa_pkg::CXA_MLEN_1M;
    p.mcount = 3'h1;
    p.rd_m = cxa_pkg::CXA_MNONE;
    p.wr_m = cxa_pkg::CXA_MNONE;
    if (b0 == cxa_pkg::CXA_OPC_PFX_X || b0 == cxa_pkg::CXA_OPC_PFX_Y)
    begin
      // Prefix, opcode, displacement
      p.use_y = (b0 == cxa_pkg::CXA_OPC_PFX_Y);
      p.src = cxa_pkg::CXA_SRC_IDX;
      if (b1 == cxa_pkg::CXA_OPC_CP_MEM || b1 == cxa_pkg::CXA_OPC_XOR_MEM)
      begin
        p.legal = 1'b1;
        p.op = (b1 == cxa_pkg::CXA_OPC_CP_MEM) ? cxa_pkg::CXA_OP_CP : cxa_pkg::CXA_OP_XOR;
        p.mlen = cxa_pkg::CXA_MLEN_5M;
        p.mcount = 3'h5;
        p.rd_m = 3'h4;
      end
      else if (b1 == cxa_pkg::CXA_OPC_INC_MEM)
      begin
        p.legal = 1'b1;
        p.op = cxa_pkg::CXA_OP_INC;
        p.mlen = cxa_pkg::CXA_MLEN_6M;
        p.mcount = 3'h6;
        p.rd_m = 3'h4;
        p.wr_m = 3'h5;
      end
    end
    else if (b0 == cxa_pkg::CXA_OPC_CP_IMM || b0 == cxa_pkg::CXA_OPC_XOR_IMM)
    begin
      p.legal = 1'b1;
      p.op = (b0 == cxa_pkg::CXA_OPC_CP_IMM) ? cxa_pkg::CXA_OP_CP : cxa_pkg::CXA_OP_XOR;
      p.src = cxa_pkg::CXA_SRC_IMM;
      p.mlen = cxa_pkg::CXA_MLEN_2M;
      p.mcount = 3'h2;
    end
    else if (b0 == cxa_pkg::CXA_OPC_CP_MEM || b0 == cxa_pkg::CXA_OPC_XOR_MEM)
    begin
      p.legal = 1'b1;
      p.op = (b0 == cxa_pkg::CXA_OPC_CP_MEM) ? cxa_pkg::CXA_OP_CP : cxa_pkg::CXA_OP_XOR;
      p.src = cxa_pkg::CXA_SRC_PTR;
      p.mlen = cxa_pkg::CXA_MLEN_2M;
      p.mcount = 3'h2;
      p.rd_m = 3'h1;
    end
    else if (b0 == cxa_pkg::CXA_OPC_INC_MEM)
    begin
      p.legal = 1'b1;
      p.op = cxa_pkg::CXA_OP_INC;
      p.src = cxa_pkg::CXA_SRC_PTR;
      p.mlen = cxa_pkg::CXA_MLEN_3M;
      p.mcount = 3'h3;
      p.rd_m = 3'h1;
      p.wr_m = 3'h2;
    end
    else if (b0[2:0] != cxa_pkg::CXA_RSEL_MEM)
    begin
      // Register forms; field 110 never reaches here
      if (b0[7:3] == cxa_pkg::CXA_OPC_CP_REG)
      begin
        p.legal = 1'b1;
        p.op = cxa_pkg::CXA_OP_CP;
      end
      else if (b0[7:3] == cxa_pkg::CXA_OPC_XOR_REG)
      begin
        p.legal = 1'b1;
        p.op = cxa_pkg::CXA_OP_XOR;
      end
      else if (b0[7:6] == cxa_pkg::CXA_OPC_INC_HI && b5_is_inc(b0))
      begin
        p.legal = 1'b1;
        p.op = cxa_pkg::CXA_OP_INC;
        p.rsel = b0[5:3];
      end
    end
    return p;
  endfunction

  // Low three bits of an increment-register opcode, field must name a register
  function automatic logic b5_is_inc(input logic [7:0] b);
    return (b[2:0] == cxa_pkg::CXA_OPC_INC_LO) && (b[5:3] != cxa_pkg::CXA_RSEL_MEM);
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait state: ack comes the cycle after the request, then drops
  assign bus_req = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr = bus_req && wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign busy_o = (state_q == CXA_ST_EXEC);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= bus_req;
    end
  end

  // Read data captured with the request; unmapped offsets read zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdat_q <= '0;
    end
    else if (bus_req && !wb_we_i)
    begin
      unique case (wb_adr_i)
        cxa_pkg::CXA_OFS_INSTR: rdat_q <= {8'h00, instr_q};
        cxa_pkg::CXA_OFS_STATUS:
        begin
          rdat_q <= '0;
          rdat_q[cxa_pkg::CXA_ST_BUSY] <= busy_o;
          rdat_q[cxa_pkg::CXA_ST_ILLEGAL] <= illegal_q;
          rdat_q[cxa_pkg::CXA_ST_MCNT_LSB +: 3] <= last_m_q;
          rdat_q[cxa_pkg::CXA_ST_TCNT_LSB +: 5] <= last_t_q;
        end
        cxa_pkg::CXA_OFS_AF: rdat_q <= {16'h0000, gpr_q[7], gpr_q[6]};
        cxa_pkg::CXA_OFS_BC: rdat_q <= {16'h0000, gpr_q[0], gpr_q[1]};
        cxa_pkg::CXA_OFS_DE: rdat_q <= {16'h0000, gpr_q[2], gpr_q[3]};
        cxa_pkg::CXA_OFS_PTR: rdat_q <= {16'h0000, gpr_q[4], gpr_q[5]};
        cxa_pkg::CXA_OFS_IDX_X: rdat_q <= {16'h0000, idx_x_q};
        cxa_pkg::CXA_OFS_IDX_Y: rdat_q <= {16'h0000, idx_y_q};
        default: rdat_q <= '0;
      endcase
    end
  end

  // Byte lanes merged into the instruction word
  always_comb
  begin
    instr_d = instr_q;
    for (int i = 0; i < 3; i++)
    begin
      if (wb_sel_i[i])
      begin
        instr_d[8*i +: 8] = wb_dat_i[8*i +: 8];
      end
    end
  end

  // Writes while busy are dropped so a running instruction sees fixed state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      instr_q <= '0;
    end
    else if (bus_wr && !busy_o && wb_adr_i == cxa_pkg::CXA_OFS_INSTR)
    begin
      instr_q <= instr_d;
    end
  end

  assign plan_d = decode(instr_d);
  assign start = bus_wr && !busy_o && wb_adr_i == cxa_pkg::CXA_OFS_INSTR && plan_d.legal;

  // Illegal code reported until the next legal start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      illegal_q <= 1'b0;
    end
    else if (bus_wr && !busy_o && wb_adr_i == cxa_pkg::CXA_OFS_INSTR)
    begin
      illegal_q <= !plan_d.legal;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  cxa_mtimer #(
    .W(3)
  ) u_mtimer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(busy_o),
    .len_i(plan_q.mlen[mi_q]),
    .last_o(m_last)
  );

  assign fin = m_last && (mi_q == plan_q.mcount - 3'h1);
  assign rd_cyc = busy_o && (mi_q == plan_q.rd_m);
  assign wr_cyc = busy_o && (mi_q == plan_q.wr_m);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= CXA_ST_IDLE;
      plan_q <= '0;
      mi_q <= '0;
    end
    else
    begin
      unique case (state_q)
        CXA_ST_IDLE:
        begin
          if (start)
          begin
            state_q <= CXA_ST_EXEC;
            plan_q <= plan_d;
            mi_q <= '0;
          end
        end
        CXA_ST_EXEC:
        begin
          if (fin)
          begin
            state_q <= CXA_ST_IDLE;
          end
          else if (m_last)
          begin
            mi_q <= mi_q + 3'h1;
          end
        end
      endcase
    end
  end

  // T-state count of the running and the last finished instruction
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      tcnt_q <= '0;
      last_t_q <= '0;
      last_m_q <= '0;
    end
    else if (start)
    begin
      tcnt_q <= '0;
    end
    else if (busy_o)
    begin
      tcnt_q <= tcnt_q + 5'h01;
      if (fin)
      begin
        last_t_q <= tcnt_q + 5'h01;
        last_m_q <= plan_q.mcount;
      end
    end
  end

  // ----------------------------------------------------------------
  // Memory access
  // ----------------------------------------------------------------
  assign disp_ext = {{8{plan_d.disp[7]}}, plan_d.disp};
  assign idx_base = plan_d.use_y ? idx_y_q : idx_x_q;

  // Address fixed at start; 16-bit sum wraps naturally
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q <= '0;
    end
    else if (start)
    begin
      if (plan_d.src == cxa_pkg::CXA_SRC_IDX)
      begin
        addr_q <= idx_base + disp_ext;
      end
      else
      begin
        addr_q <= {gpr_q[4], gpr_q[5]};
      end
    end
  end

  // Operand and write-back byte caught at the end of the read cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      opnd_q <= '0;
      wdata_q <= '0;
    end
    else if (rd_cyc && m_last)
    begin
      opnd_q <= mem_rdata_i;
      wdata_q <= alu_res;
    end
  end

  assign mem_req_o.addr = addr_q;
  assign mem_req_o.rd = rd_cyc;
  assign mem_req_o.wr = wr_cyc;
  assign mem_req_o.wdata = wdata_q;

  // ----------------------------------------------------------------
  // Operand selection and ALU
  // ----------------------------------------------------------------
  assign mem_src = (plan_q.src == cxa_pkg::CXA_SRC_PTR) || (plan_q.src == cxa_pkg::CXA_SRC_IDX);

  // Memory data is used live in its read cycle, latched copy afterwards
  always_comb
  begin
    if (mem_src)
    begin
      src_byte = rd_cyc ? mem_rdata_i : opnd_q;
    end
    else if (plan_q.src == cxa_pkg::CXA_SRC_IMM)
    begin
      src_byte = plan_q.imm;
    end
    else
    begin
      src_byte = gpr_q[plan_q.rsel];
    end
  end

  cxa_alu u_alu (
    .op_i(plan_q.op),
    .acc_i(gpr_q[cxa_pkg::CXA_RSEL_ACC]),
    .src_i(src_byte),
    .flags_i(gpr_q[cxa_pkg::CXA_RSEL_MEM]),
    .res_o(alu_res),
    .flags_o(alu_flags)
  );

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  // Bus writes land only when idle, so they never collide with execution
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < 8; i++)
      begin
        gpr_q[i] <= cxa_pkg::CXA_RST_BYTE;
      end
    end
    else if (fin)
    begin
      gpr_q[cxa_pkg::CXA_RSEL_MEM] <= alu_flags;
      if (plan_q.op == cxa_pkg::CXA_OP_XOR)
      begin
        gpr_q[cxa_pkg::CXA_RSEL_ACC] <= alu_res;
      end
      else if (plan_q.op == cxa_pkg::CXA_OP_INC && !mem_src)
      begin
        gpr_q[plan_q.rsel] <= alu_res;
      end
    end
    else if (bus_wr && !busy_o)
    begin
      unique case (wb_adr_i)
        cxa_pkg::CXA_OFS_AF:
        begin
          if (wb_sel_i[1]) gpr_q[7] <= wb_dat_i[15:8];
          if (wb_sel_i[0]) gpr_q[6] <= wb_dat_i[7:0];
        end
        cxa_pkg::CXA_OFS_BC:
        begin
          if (wb_sel_i[1]) gpr_q[0] <= wb_dat_i[15:8];
          if (wb_sel_i[0]) gpr_q[1] <= wb_dat_i[7:0];
        end
        cxa_pkg::CXA_OFS_DE:
        begin
          if (wb_sel_i[1]) gpr_q[2] <= wb_dat_i[15:8];
          if (wb_sel_i[0]) gpr_q[3] <= wb_dat_i[7:0];
        end
        cxa_pkg::CXA_OFS_PTR:
        begin
          if (wb_sel_i[1]) gpr_q[4] <= wb_dat_i[15:8];
          if (wb_sel_i[0]) gpr_q[5] <= wb_dat_i[7:0];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Index registers, software loaded only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      idx_x_q <= cxa_pkg::CXA_RST_WORD;
      idx_y_q <= cxa_pkg::CXA_RST_WORD;
    end
    else if (bus_wr && !busy_o)
    begin
      if (wb_adr_i == cxa_pkg::CXA_OFS_IDX_X)
      begin
        if (wb_sel_i[1]) idx_x_q[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[0]) idx_x_q[7:0] <= wb_dat_i[7:0];
      end
      if (wb_adr_i == cxa_pkg::CXA_OFS_IDX_Y)
      begin
        if (wb_sel_i[1]) idx_y_q[15:8] <= wb_dat_i[15:8];
        if (wb_sel_i[0]) idx_y_q[7:0] <= wb_dat_i[7:0];
      end
    end
  end

endmodule

`default_nettype wire

// ### core/cxa_mtimer.sv
// T-state counter for one machine cycle of programmable length.
// Assumes len_i stays stable while run_i is high within a machine cycle.

`timescale 1ns/1ns
`default_nettype none

module cxa_mtimer #(
  parameter int unsigned W = 3
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [W-1:0] len_i,
  output logic last_o
);

  logic [W-1:0] cnt_q;

  // --------------------------------------------------------------
  // Counting
  // --------------------------------------------------------------
  // Last T state of the current machine cycle
  assign last_o = run_i && (cnt_q == len_i - W'(1));

  // Restarts at zero so the next machine cycle begins cleanly
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || last_o)
    begin
      cnt_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_q + W'(1);
    end
  end

endmodule

`default_nettype wire

// ### core/cxa_pkg.sv
// Shared types and constants for the compare/exclusive-OR/increment execution unit.
// Assumes a single 25 MHz clock where one T state is one clock cycle.

package cxa_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the Wishbone slave)
  // ----------------------------------------------------------------
  localparam logic [7:0] CXA_OFS_INSTR = 8'h00;
  localparam logic [7:0] CXA_OFS_STATUS = 8'h04;
  localparam logic [7:0] CXA_OFS_AF = 8'h08;
  localparam logic [7:0] CXA_OFS_BC = 8'h0C;
  localparam logic [7:0] CXA_OFS_DE = 8'h10;
  localparam logic [7:0] CXA_OFS_PTR = 8'h14;
  localparam logic [7:0] CXA_OFS_IDX_X = 8'h18;
  localparam logic [7:0] CXA_OFS_IDX_Y = 8'h1C;

  // Status fields
  localparam int unsigned CXA_ST_BUSY = 0;
  localparam int unsigned CXA_ST_ILLEGAL = 1;
  localparam int unsigned CXA_ST_MCNT_LSB = 8;
  localparam int unsigned CXA_ST_TCNT_LSB = 16;

  // Flag bit positions inside the flag byte
  localparam int unsigned CXA_FLAG_S = 7;
  localparam int unsigned CXA_FLAG_Z = 6;
  localparam int unsigned CXA_FLAG_H = 4;
  localparam int unsigned CXA_FLAG_PV = 2;
  localparam int unsigned CXA_FLAG_N = 1;
  localparam int unsigned CXA_FLAG_C = 0;

  // Reset values
  localparam logic [7:0] CXA_RST_BYTE = 8'h00;
  localparam logic [15:0] CXA_RST_WORD = 16'h0000;

  // ----------------------------------------------------------------
  // Opcode bytes
  // ----------------------------------------------------------------
  localparam logic [4:0] CXA_OPC_CP_REG = 5'h17;   // 10111 rrr
  localparam logic [4:0] CXA_OPC_XOR_REG = 5'h15;  // 10101 rrr
  localparam logic [1:0] CXA_OPC_INC_HI = 2'h0;    // 00 rrr 100
  localparam logic [2:0] CXA_OPC_INC_LO = 3'h4;
  localparam logic [7:0] CXA_OPC_CP_IMM = 8'hFE;
  localparam logic [7:0] CXA_OPC_CP_MEM = 8'hBE;
  localparam logic [7:0] CXA_OPC_XOR_IMM = 8'hEE;
  localparam logic [7:0] CXA_OPC_XOR_MEM = 8'hAE;
  localparam logic [7:0] CXA_OPC_INC_MEM = 8'h34;
  localparam logic [7:0] CXA_OPC_PFX_X = 8'hDD;
  localparam logic [7:0] CXA_OPC_PFX_Y = 8'hFD;
  localparam logic [2:0] CXA_RSEL_MEM = 3'h6;      // Names memory, never a register
  localparam logic [2:0] CXA_RSEL_ACC = 3'h7;

  // ----------------------------------------------------------------
  // Machine cycle timing, element 0 is the opcode fetch cycle
  // ----------------------------------------------------------------
  typedef logic [5:0][2:0] cxa_mlen_t;
  localparam cxa_mlen_t CXA_MLEN_1M = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h4};
  localparam cxa_mlen_t CXA_MLEN_2M = {3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h4};
  localparam cxa_mlen_t CXA_MLEN_3M = {3'h0, 3'h0, 3'h0, 3'h3, 3'h4, 3'h4};
  localparam cxa_mlen_t CXA_MLEN_5M = {3'h0, 3'h3, 3'h5, 3'h3, 3'h4, 3'h4};
  localparam cxa_mlen_t CXA_MLEN_6M = {3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
  localparam logic [2:0] CXA_MNONE = 3'h7;         // No memory access cycle

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {CXA_OP_NONE, CXA_OP_CP, CXA_OP_XOR, CXA_OP_INC} cxa_op_t;
  typedef enum logic [1:0] {CXA_SRC_REG, CXA_SRC_IMM, CXA_SRC_PTR, CXA_SRC_IDX} cxa_src_t;

  typedef struct packed {
    logic legal;
    cxa_op_t op;
    cxa_src_t src;
    logic [2:0] rsel;
    logic use_y;
    logic [7:0] imm;
    logic [7:0] disp;
    cxa_mlen_t mlen;
    logic [2:0] mcount;
    logic [2:0] rd_m;
    logic [2:0] wr_m;
  } cxa_plan_t;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic wr;
    logic [7:0] wdata;
  } cxa_mem_req_t;

endpackage

// ### verif/cxa_core_assertions.sv
// Checker for cxa_core, watching its ports only.
// Assumes attachment to every cxa_core by the bind at the foot.
`timescale 1ns/1ns
`default_nettype none
module cxa_core_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire cxa_pkg::cxa_mem_req_t mem_req_o,
  input wire logic [7:0] mem_rdata_i,
  input wire logic busy_o
);
  // ----------------------------------------
  // Busy length counter
  // ----------------------------------------
  logic [4:0] bcnt_q;
  // Cleared while idle, so it holds the T count when busy falls
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !busy_o)
      bcnt_q <= 5'h00;
    else
      bcnt_q <= bcnt_q + 5'h01;
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  busy_len_a: assert property ($fell(busy_o) |-> bcnt_q inside {5'h04, 5'h07, 5'h0B, 5'h13, 5'h17})
    else $error("instruction length wrong");
  rd_wr_excl_a: assert property (!(mem_req_o.rd && mem_req_o.wr))
    else $error("read and write together");
  mem_idle_a: assert property (!busy_o |-> !mem_req_o.rd && !mem_req_o.wr)
    else $error("memory access while idle");
  wr_last_a: assert property ($fell(mem_req_o.wr) |-> $fell(busy_o))
    else $error("write not in last cycle");
  wr_len_a: assert property ($rose(mem_req_o.wr) |-> mem_req_o.wr [*3] ##1 !mem_req_o.wr)
    else $error("write cycle not three states");
  wr_stable_a: assert property (mem_req_o.wr && $past(mem_req_o.wr) |-> $stable(mem_req_o))
    else $error("write address or data moved");
endmodule
bind cxa_core cxa_core_chk u_chk (.*);
`default_nettype wire

// ### verif/cxa_core_tb.sv
// Self-checking bench for cxa_core over classic Wishbone.
// Assumes a combinational byte memory modelled here.
`timescale 1ns/1ns
`default_nettype none
module cxa_core_tb;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic we = 1'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] dato;
  logic [31:0] rdat;
  logic ack;
  logic busy;
  cxa_pkg::cxa_mem_req_t mreq;
  logic [7:0] mem [0:65535];
  logic [7:0] mrd;
  logic [7:0] sv [8] = '{8'h60, 8'h63, 8'h80, 8'h7F, 8'h60, 8'h00, 8'h00, 8'h63};
  int n_mismatch = 0;
  int checked = 0;
  cxa_core DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack),
    .mem_req_o(mreq), .mem_rdata_i(mrd), .busy_o(busy));
  // Memory answers in the same cycle
  assign mrd = mem[mreq.addr];
  always @(posedge clk_i)
    if (mreq.wr)
      mem[mreq.addr] <= mreq.wdata;
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One classic cycle; no latency assumed, the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'h1)
      @(posedge clk_i);
    rdat = dato;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask
  task automatic run(input logic [23:0] c, input logic [4:0] t);
    xfer(1'h1, 8'h00, {8'h00, c});
    rdat = 32'h1;
    while (rdat[0] !== 1'h0)
      xfer(1'h0, 8'h04, 32'h0);
    chk("tstates", {27'h0, rdat[20:16]}, {27'h0, t});
    chk("busy", {31'h0, busy}, 32'h0);
  endtask
  function automatic logic [7:0] cpf(input logic [7:0] a, input logic [7:0] s);
    logic [7:0] d;
    d = a - s;
    return {d[7], d == 8'h00, 1'h0, a[3:0] < s[3:0], 1'h0,
      (a[7] ^ s[7]) & (d[7] ^ a[7]), 1'h1, a < s};
  endfunction
  task automatic cpchk(input logic [23:0] c, input logic [4:0] t, input logic [7:0] s);
    run(c, t);
    xfer(1'h0, 8'h08, 32'h0);
    chk("cp_af", rdat, {16'h0, 8'h63, cpf(8'h63, s)});
    $display("done compare %h", c);
  endtask
  task automatic incchk(input logic [23:0] c, input logic [4:0] t, input logic [15:0] a,
    input logic [7:0] m, input logic [7:0] f);
    run(c, t);
    chk("inc_mem", {24'h0, mem[a]}, {24'h0, m});
    xfer(1'h0, 8'h08, 32'h0);
    chk("inc_af", rdat, {16'h0, 8'h63, f});
    $display("done increment %h", c);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    mem[16'h6000] = 8'h60;
    mem[16'h2030] = 8'h34;
    mem[16'hFFF5] = 8'h7F;
    mem[16'h3434] = 8'hFF;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    xfer(1'h0, 8'h08, 32'h0);
    chk("af_reset", rdat, 32'h0);
    $display("done reset values");
    xfer(1'h1, 8'h08, 32'h9600);
    run(24'h005DEE, 5'h07);
    xfer(1'h0, 8'h08, 32'h0);
    chk("xor_af", rdat, 32'hCB80);
    $display("done exclusive-OR immediate");
    xfer(1'h1, 8'h08, 32'h6300);
    xfer(1'h1, 8'h0C, 32'h6063);
    xfer(1'h1, 8'h10, 32'h807F);
    xfer(1'h1, 8'h14, 32'h6000);
    xfer(1'h1, 8'h18, 32'h2020);
    xfer(1'h1, 8'h1C, 32'h0005);
    // Every register field, incl. equality and signed overflow
    for (int r = 0; r < 8; r++)
      if (r != 6)
        cpchk({16'h0, 5'h17, r[2:0]}, 5'h04, sv[r]);
    cpchk(24'h0064FE, 5'h07, 8'h64);
    cpchk(24'h0000BE, 5'h07, 8'h60);
    cpchk(24'h10BEDD, 5'h13, 8'h34);
    cpchk(24'hF0BEFD, 5'h13, 8'h7F);
    xfer(1'h1, 8'h08, 32'h6301);
    incchk(24'h00001C, 5'h04, 16'h6000, 8'h60, 8'h95);
    xfer(1'h0, 8'h10, 32'h0);
    chk("inc_reg", rdat, 32'h8080);
    xfer(1'h1, 8'h14, 32'h3434);
    incchk(24'h000034, 5'h0B, 16'h3434, 8'h00, 8'h51);
    incchk(24'h1034DD, 5'h17, 16'h2030, 8'h35, 8'h01);
    incchk(24'hF034FD, 5'h17, 16'hFFF5, 8'h80, 8'h95);
    // Illegal code: no start, last counts of the indexed increment kept
    xfer(1'h1, 8'h00, 32'h0000ED);
    xfer(1'h0, 8'h04, 32'h0);
    chk("illegal", rdat, 32'h00170602);
    $display("done illegal code");
    // Accumulator against itself, then indexed exclusive-OR
    run(24'h0000AF, 5'h04);
    chk("status_xor", rdat, 32'h00040100);
    xfer(1'h0, 8'h08, 32'h0);
    chk("xor_reg_af", rdat, 32'h0044);
    run(24'h10AEDD, 5'h13);
    xfer(1'h0, 8'h08, 32'h0);
    chk("xor_idx_af", rdat, 32'h3504);
    $display("done exclusive-OR register and indexed");
    summarize();
  end
  initial
  begin
    #400000;
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
